// file: core_host_pkg.sv
// constants and types for the core memory cycle host controller
package core_host_pkg;
   // -------------------------------------------------------------
   // clock and timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   // least command pulse width at the device pins
   localparam int CMD_PULSE_NS = 100;
   // least address and data setup before a command pulse
   localparam int ADDR_SETUP_NS = 50;
   // longest wait for busy to rise, and for busy to fall again
   localparam int BUSY_TIMEOUT_NS = 10000;
   localparam int CNT_W = 12;

   // least times round up, longest times round down, never below one
   function automatic logic [CNT_W-1:0] cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return CNT_W'(c);
   endfunction

   function automatic logic [CNT_W-1:0] cyc_down(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return CNT_W'(c);
   endfunction

   localparam logic [CNT_W-1:0] CMD_PULSE_CYC = cyc_up(CMD_PULSE_NS);
   localparam logic [CNT_W-1:0] ADDR_SETUP_CYC = cyc_up(ADDR_SETUP_NS);
   localparam logic [CNT_W-1:0] BUSY_TIMEOUT_CYC = cyc_down(BUSY_TIMEOUT_NS);

   // -------------------------------------------------------------
   // widths
   // -------------------------------------------------------------
   localparam int ADDR_W_DEF = 6;
   localparam int DATA_W_DEF = 16;

   // -------------------------------------------------------------
   // cycle kinds and sequencer states
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_READ_REGEN  = 2'b00,
      OP_CLEAR_WRITE = 2'b01,
      OP_LOAD        = 2'b10,
      OP_UNLOAD      = 2'b11
   } op_t;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_SETUP     = 3'b001,
      ST_PULSE     = 3'b010,
      ST_WAIT_BUSY = 3'b011,
      ST_WAIT_DONE = 3'b100
   } state_t;
endpackage

// file: pin_sync_if.sv
// synchronised device pin levels passed from the synchroniser to the host
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(
   parameter int DATA_W = 16
);
   logic busy;
   logic [DATA_W-1:0] word_true;
   logic [DATA_W-1:0] word_comp;

   modport src (
      output busy,
      output word_true,
      output word_comp
   );
   modport dst (
      input busy,
      input word_true,
      input word_comp
   );
endinterface
`default_nettype wire

// file: pin_sync.sv
// two-flop synchroniser for the device busy and double-rail word pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int DATA_W = 16
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic busy_i,
   input wire logic [DATA_W-1:0] true_i,
   input wire logic [DATA_W-1:0] comp_i,
   pin_sync_if.src sync
);
   localparam int W = 2 * DATA_W + 1;

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   always_comb begin
      s_d = s_q;
      // first stage feeds only the second stage
      s_d.meta = {busy_i, true_i, comp_i};
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign sync.busy = s_q.stable[W-1];
   assign sync.word_true = s_q.stable[W-2:DATA_W];
   assign sync.word_comp = s_q.stable[DATA_W-1:0];
endmodule
`default_nettype wire

// file: core_mem_host.sv
// host controller issuing cycle commands to a core memory sequencer
`timescale 1ns/1ps
`default_nettype none
module core_mem_host
   import core_host_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int DATA_W = DATA_W_DEF
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // user request side
   input wire logic req_valid_i,
   input wire logic [1:0] req_op_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic rsp_err_o,
   output logic [DATA_W-1:0] rsp_rdata_o,
   // device pins
   output logic read_regen_cmd_o,
   output logic clear_write_cmd_o,
   output logic load_cmd_o,
   output logic unload_cmd_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] data_o,
   input wire logic memory_busy_out_i,
   input wire logic [DATA_W-1:0] info_true_i,
   input wire logic [DATA_W-1:0] info_comp_i
);
   localparam int DEPTH = 2 ** ADDR_W;

   typedef struct packed {
      state_t state;
      op_t op;
      logic [CNT_W-1:0] cnt;
      logic ready;
      logic rsp_valid;
      logic rsp_err;
      logic [DATA_W-1:0] rdata;
      logic [3:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [DEPTH-1:0] cleared;
   } host_state_t;

   host_state_t s_q;
   host_state_t s_d;

   pin_sync_if #(.DATA_W(DATA_W)) pins ();

   pin_sync #(
      .DATA_W(DATA_W)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .busy_i(memory_busy_out_i),
      .true_i(info_true_i),
      .comp_i(info_comp_i),
      .sync(pins.src)
   );

   // one-hot command line for a cycle kind
   function automatic logic [3:0] cmd_line(input op_t op);
      logic [3:0] v;
      v = 4'h0;
      case (op)
         OP_READ_REGEN: v = 4'h1;
         OP_CLEAR_WRITE: v = 4'h2;
         OP_LOAD: v = 4'h4;
         OP_UNLOAD: v = 4'h8;
         default: v = 4'h0;
      endcase
      return v;
   endfunction

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rsp_valid = 1'b0;
      s_d.rsp_err = 1'b0;
      case (s_q.state)
         ST_IDLE: begin
            s_d.ready = ~pins.busy;
            if (req_valid_i && s_q.ready && !pins.busy) begin
               s_d.ready = 1'b0;
               if (op_t'(req_op_i) == OP_LOAD &&
                   !s_q.cleared[req_addr_i]) begin
                  s_d.rsp_valid = 1'b1;
                  s_d.rsp_err = 1'b1;
               end else begin
                  s_d.op = op_t'(req_op_i);
                  s_d.addr = req_addr_i;
                  s_d.data = req_wdata_i;
                  s_d.cnt = ADDR_SETUP_CYC;
                  s_d.state = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            if (s_q.cnt == CNT_W'(1)) begin
               s_d.cmd = cmd_line(s_q.op);
               s_d.cnt = CMD_PULSE_CYC;
               s_d.state = ST_PULSE;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         ST_PULSE: begin
            if (s_q.cnt == CNT_W'(1)) begin
               s_d.cmd = 4'h0;
               s_d.cnt = BUSY_TIMEOUT_CYC;
               s_d.state = ST_WAIT_BUSY;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         ST_WAIT_BUSY: begin
            if (pins.busy) begin
               s_d.cnt = BUSY_TIMEOUT_CYC;
               s_d.state = ST_WAIT_DONE;
            end else if (s_q.cnt == CNT_W'(1)) begin
               s_d.rsp_valid = 1'b1;
               s_d.rsp_err = 1'b1;
               s_d.cleared[s_q.addr] = 1'b0;
               s_d.state = ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         ST_WAIT_DONE: begin
            // busy falls after the inhibit step ends
            if (!pins.busy) begin
               s_d.rsp_valid = 1'b1;
               s_d.state = ST_IDLE;
               if (s_q.op == OP_READ_REGEN || s_q.op == OP_UNLOAD) begin
                  s_d.rsp_err = (pins.word_true != ~pins.word_comp);
                  // read word returned to the user
                  s_d.rdata = pins.word_true;
               end
               s_d.cleared[s_q.addr] = (s_q.op == OP_UNLOAD);
            end else if (s_q.cnt == CNT_W'(1)) begin
               s_d.rsp_valid = 1'b1;
               s_d.rsp_err = 1'b1;
               s_d.cleared[s_q.addr] = 1'b0;
               s_d.state = ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         default: begin
            s_d.state = ST_IDLE;
            s_d.cmd = 4'h0;
            s_d.ready = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // outputs, all straight from flops
   // -------------------------------------------------------------
   assign req_ready_o = s_q.ready;
   assign rsp_valid_o = s_q.rsp_valid;
   assign rsp_err_o = s_q.rsp_err;
   assign rsp_rdata_o = s_q.rdata;
   assign read_regen_cmd_o = s_q.cmd[0];
   assign clear_write_cmd_o = s_q.cmd[1];
   assign load_cmd_o = s_q.cmd[2];
   assign unload_cmd_o = s_q.cmd[3];
   assign addr_o = s_q.addr;
   assign data_o = s_q.data;
endmodule
`default_nettype wire

// file: core_mem_host_properties.sv
// port assertions for the core memory host controller
`timescale 1ns/1ps
`default_nettype none
module core_mem_host_checker #(
   parameter int ADDR_W = 6,
   parameter int DATA_W = 16
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic req_valid_i,
   input wire logic [1:0] req_op_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic read_regen_cmd_o,
   input wire logic clear_write_cmd_o,
   input wire logic load_cmd_o,
   input wire logic unload_cmd_o,
   input wire logic [ADDR_W-1:0] addr_o,
   input wire logic memory_busy_out_i
);
   wire logic any_c = read_regen_cmd_o | clear_write_cmd_o | load_cmd_o
      | unload_cmd_o;
   wire logic take = req_valid_i & req_ready_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   a_cmd_one_line:
      assert property ($onehot0({read_regen_cmd_o, clear_write_cmd_o,
         load_cmd_o, unload_cmd_o})) else $error("two command lines");
   a_cmd_width:
      assert property ($rose(any_c) |-> ##19 any_c ##1 !any_c)
         else $error("command width");
   a_ready_drop:
      assert property (take |=> !req_ready_o) else $error("ready held");
   a_cmd_not_ready:
      assert property (any_c |-> !req_ready_o) else $error("ready in cmd");
   a_busy_no_ready:
      assert property (memory_busy_out_i [*5] |-> !req_ready_o)
         else $error("ready while busy");
   a_rsp_once:
      assert property (rsp_valid_o |=> !rsp_valid_o) else $error("rsp long");
   a_addr_take:
      assert property (take && req_op_i != 2'b10 |=>
         addr_o == $past(req_addr_i)) else $error("address not taken");
   a_addr_stable:
      assert property (any_c |-> $stable(addr_o)) else $error("addr moved");
   a_unload_map:
      assert property (take && req_op_i == 2'b11 |-> ##11 unload_cmd_o)
         else $error("unload line");
   a_cw_map:
      assert property (take && req_op_i == 2'b01 |-> ##11 clear_write_cmd_o)
         else $error("clear write line");
endmodule
bind core_mem_host core_mem_host_checker #(
   .ADDR_W(ADDR_W),
   .DATA_W(DATA_W)
) u_chk (
   .sys_clk_i(sys_clk_i),
   .srst_i(srst_i),
   .req_valid_i(req_valid_i),
   .req_op_i(req_op_i),
   .req_addr_i(req_addr_i),
   .req_ready_o(req_ready_o),
   .rsp_valid_o(rsp_valid_o),
   .read_regen_cmd_o(read_regen_cmd_o),
   .clear_write_cmd_o(clear_write_cmd_o),
   .load_cmd_o(load_cmd_o),
   .unload_cmd_o(unload_cmd_o),
   .addr_o(addr_o),
   .memory_busy_out_i(memory_busy_out_i)
);
`default_nettype wire

// file: core_mem_model.sv
// behavioural core memory answering the host command pins
`timescale 1ns/1ps
`default_nettype none
module core_mem_model
   import core_host_pkg::*;
(
   input wire logic rr_i,
   input wire logic cw_i,
   input wire logic ld_i,
   input wire logic ul_i,
   input wire logic [ADDR_W_DEF-1:0] addr_i,
   input wire logic [DATA_W_DEF-1:0] data_i,
   output logic busy_o,
   output logic [DATA_W_DEF-1:0] true_o,
   output logic [DATA_W_DEF-1:0] comp_o
);
   logic [15:0] mem [64];
   logic [15:0] ir;
   logic [5:0] a;
   logic [3:0] k;
   assign true_o = ir;
   assign comp_o = ~ir;
   initial begin
      busy_o = 1'b0;
      ir = 16'h0000;
      foreach (mem[i]) mem[i] = 16'h3C3C;
      forever begin
         @(posedge rr_i or posedge cw_i or posedge ld_i or posedge ul_i);
         busy_o = 1'b1;
         a = addr_i;
         k = {ul_i, ld_i, cw_i, rr_i};
         #150;
         if (k[0] | k[3]) ir = mem[a];
         if (k[1] | k[2]) ir = data_i;
         if (!k[2]) mem[a] = 16'h0000;
         if (!k[3]) mem[a] = mem[a] | ir;
         #200;
         busy_o = 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: core_mem_host_tb.sv
// self-checking bench for the core memory host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin \
   err_count++; $display("[ERR] %s exp %h seen %h", n, e, s); end end
module core_mem_host_tb
   import core_host_pkg::*;
;
   logic sys_clk_i, srst_i, ce_i, req_valid_i;
   logic [1:0] req_op_i;
   logic [5:0] req_addr_i, addr_o;
   logic [15:0] req_wdata_i, data_o, rsp_rdata_o, info_true_i, info_comp_i;
   logic req_ready_o, rsp_valid_o, rsp_err_o, memory_busy_out_i;
   logic read_regen_cmd_o, clear_write_cmd_o, load_cmd_o, unload_cmd_o;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   core_mem_host u_dut (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .req_valid_i(req_valid_i),
      .req_op_i(req_op_i),
      .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i),
      .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o),
      .rsp_err_o(rsp_err_o),
      .rsp_rdata_o(rsp_rdata_o),
      .read_regen_cmd_o(read_regen_cmd_o),
      .clear_write_cmd_o(clear_write_cmd_o),
      .load_cmd_o(load_cmd_o),
      .unload_cmd_o(unload_cmd_o),
      .addr_o(addr_o),
      .data_o(data_o),
      .memory_busy_out_i(memory_busy_out_i),
      .info_true_i(info_true_i),
      .info_comp_i(info_comp_i)
   );
   core_mem_model u_mem (.rr_i(read_regen_cmd_o), .cw_i(clear_write_cmd_o),
      .ld_i(load_cmd_o), .ul_i(unload_cmd_o), .addr_i(addr_o),
      .data_i(data_o), .busy_o(memory_busy_out_i), .true_o(info_true_i),
      .comp_o(info_comp_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic do_op(input logic [1:0] op, input logic [5:0] a,
      input logic [15:0] d, output logic e, output logic [15:0] r);
      int n;
      @(negedge sys_clk_i);
      req_valid_i = 1'b1;
      req_op_i = op;
      req_addr_i = a;
      req_wdata_i = d;
      // ready seen mid-cycle stands through the taking edge
      while (req_ready_o !== 1'b1) begin
         @(negedge sys_clk_i);
      end
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      req_valid_i = 1'b0;
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 6000) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n >= 6000) begin
         err_count++;
         $display("[ERR] no answer to request");
      end
      e = rsp_err_o;
      r = rsp_rdata_o;
   endtask
   task automatic t_write_read();
      logic e;
      logic [15:0] r;
      do_op(OP_CLEAR_WRITE, 6'h05, 16'hA5C3, e, r);
      `CHK("cw_err", 1'b0, e)
      do_op(OP_READ_REGEN, 6'h05, 16'h0000, e, r);
      `CHK("rr_word", 16'hA5C3, r)
      do_op(OP_READ_REGEN, 6'h05, 16'h0000, e, r);
      `CHK("rr_again", 16'hA5C3, r)
      `CHK("rr_err", 1'b0, e)
   endtask
   task automatic t_unload_load();
      logic e;
      logic [15:0] r;
      do_op(OP_UNLOAD, 6'h05, 16'h0000, e, r);
      `CHK("ul_word", 16'hA5C3, r)
      do_op(OP_LOAD, 6'h05, 16'h0F0F, e, r);
      `CHK("ld_err", 1'b0, e)
      do_op(OP_UNLOAD, 6'h05, 16'h0000, e, r);
      `CHK("ld_word", 16'h0F0F, r)
      do_op(OP_READ_REGEN, 6'h05, 16'h0000, e, r);
      `CHK("ul_cleared", 16'h0000, r)
   endtask
   task automatic t_load_refused();
      logic e;
      logic [15:0] r;
      do_op(OP_LOAD, 6'h09, 16'hFFFF, e, r);
      `CHK("ld_refused", 1'b1, e)
      do_op(OP_READ_REGEN, 6'h09, 16'h0000, e, r);
      `CHK("ld_no_write", 16'h3C3C, r)
   endtask
   initial begin
      srst_i = 1'b1;
      ce_i = 1'b1;
      req_valid_i = 1'b0;
      req_op_i = OP_READ_REGEN;
      req_addr_i = 6'h00;
      req_wdata_i = 16'h0000;
      repeat (3) @(negedge sys_clk_i);
      srst_i = 1'b0;
      t_write_read();
      t_unload_load();
      t_load_refused();
      wrap_up();
   end
endmodule
`default_nettype wire
